// ---- dis_pkg.sv ----
// constants shared by the drive digital input and relay select block
package dis_pkg;
	localparam int DIS_CLK_HZ = 50000000;
	localparam int DIS_SCAN_SHORT_MS = 4;
	localparam int DIS_SCAN_LONG_MS = 8;
	localparam int DIS_SCAN_SHORT_CYC = DIS_SCAN_SHORT_MS * (DIS_CLK_HZ / 1000);
	localparam int DIS_SCAN_LONG_CYC = DIS_SCAN_LONG_MS * (DIS_CLK_HZ / 1000);
	localparam int DIS_QUAL_CNT_W = 19;
	localparam int DIS_NUM_IN = 8;
	localparam int DIS_NUM_DET = 3;

	// register indices, byte address is four times the index
	localparam logic [3:0] DIS_IDX_SCAN = 4'h0;
	localparam logic [3:0] DIS_IDX_POL_LO = 4'h1;
	localparam logic [3:0] DIS_IDX_POL_HI = 4'h2;
	localparam logic [3:0] DIS_IDX_RELAY1 = 4'h3;
	localparam logic [3:0] DIS_IDX_RELAY2 = 4'h4;
	localparam logic [3:0] DIS_IDX_FUNC_LO = 4'h5;
	localparam logic [3:0] DIS_IDX_FUNC_HI = 4'h6;
	localparam logic [3:0] DIS_IDX_CTRL = 4'h7;
	localparam logic [3:0] DIS_IDX_DET1 = 4'h8;
	localparam logic [3:0] DIS_IDX_STATUS = 4'hB;
	localparam int DIS_NUM_RW = 11;
	localparam logic [31:0] DIS_RESET_VAL = 32'h0000_0000;
	localparam logic [10:0][31:0] DIS_MASK = {
		32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FF37,
		32'h3F3F_3F3F, 32'h3F3F_3F3F, 32'h0000_003F, 32'h0000_003F,
		32'h0000_000F, 32'h0000_000F, 32'h0000_0001};

	// control register fields
	localparam int DIS_CTRL_SLEEP_LSB = 0;
	localparam int DIS_CTRL_PROTECT = 2;
	localparam int DIS_CTRL_SAFETY_LSB = 4;
	localparam int DIS_CTRL_KEB_LSB = 8;
	localparam logic [1:0] DIS_SLEEP_SRC_DI = 2'h2;

	// input function codes
	localparam logic [5:0] DIS_FN_SLEEP = 6'h29;
	localparam logic [5:0] DIS_FN_ENC_OFF = 6'h2A;
	localparam logic [5:0] DIS_FN_INTEG_RST = 6'h2B;
	localparam logic [5:0] DIS_FN_SPD_TRQ = 6'h2C;
	localparam logic [5:0] DIS_FN_TRQ_NEG = 6'h2D;
	localparam logic [5:0] DIS_FN_ZERO_SERVO = 6'h2E;
	localparam logic [5:0] DIS_FN_FIRE = 6'h2F;
	localparam logic [5:0] DIS_FN_KEB = 6'h30;
	localparam logic [5:0] DIS_FN_WRITE_EN = 6'h31;
	localparam logic [5:0] DIS_FN_USP = 6'h32;
	localparam logic [5:0] DIS_FN_POS_SPD = 6'h33;
	localparam logic [5:0] DIS_FN_MULTI_POS = 6'h34;
	localparam logic [5:0] DIS_FN_TWO_WIRE = 6'h35;
	localparam logic [5:0] DIS_FN_SAFETY = 6'h3A;
	localparam logic [5:0] DIS_FN_EPS = 6'h3E;

	// relay codes that are reserved and so hold the contact open
	localparam logic [63:0] DIS_RELAY_RSVD = 64'hFFC3_DC1E_0003_8D80;

	localparam logic [1:0] DIS_RESP_OKAY = 2'h0;
	localparam logic [1:0] DIS_RESP_SLVERR = 2'h2;
endpackage

// ---- dis_input_qual.sv ----
// one input qualifier: level must stay stable for the selected time
`timescale 1ns/1ps
module dis_input_qual
	import dis_pkg::*;
#(
	parameter int CNT_W = DIS_QUAL_CNT_W
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             din,
	input  wire logic [CNT_W-1:0] limit,
	output logic                  q
);
	logic [CNT_W-1:0] cnt;
	wire differs = din != q;
	wire done = cnt >= limit - CNT_W'(1);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			q <= 1'b0;
		end else if (!differs) begin
			cnt <= '0; // any bounce restarts the wait
		end else if (done) begin
			cnt <= '0;
			q <= din;
		end else begin
			cnt <= cnt + CNT_W'(1);
		end
	end

	a_qual_accept: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(q) |-> $past(differs) && $past(done))
		else $error("qualified input changed before stable time");
	a_qual_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		!differs |=> q == $past(q))
		else $error("qualified input moved while raw level agreed");
endmodule

// ---- dis_freq_det.sv ----
// frequency threshold detector with hysteresis band
`timescale 1ns/1ps
module dis_freq_det #(
	parameter int W = 16
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] freq,
	input  wire logic [W-1:0] level,
	input  wire logic [W-1:0] band,
	output logic              above
);
	// band below the level, clamped so a wide band cannot wrap
	wire [W-1:0] lowEdge = (band > level) ? '0 : level - band;
	wire goUp = freq > level;
	wire goDown = freq < lowEdge;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			above <= 1'b0;
		end else if (goUp) begin
			above <= 1'b1;
		end else if (goDown) begin
			above <= 1'b0;
		end
	end

	a_det_rise: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(above) |-> $past(goUp))
		else $error("detector set without frequency above level");
	a_det_fall: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(above) |-> $past(goDown))
		else $error("detector cleared inside hysteresis band");
endmodule

// ---- dis_top.sv ----
// digital input conditioning, function decode and relay select with AXI4-Lite
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// What this block does
// - setting 0 waits 4 ms, 1 waits 8 ms of stable level before accepting
// - low polarity field: bit per input one to four, set means normally closed
// - high polarity field does the same for inputs five to eight
// - function 41 active with sleep source 2 enters process-loop sleep
// - function 42 disables encoder feedback and forces volts-per-hertz
// - function 43 clears speed loop integral, closed-loop modes only
// - function 44 on selects speed, off torque, only in sensor vector mode
// - function 45 inverts the torque reference sign
// - activating function 46 starts zero-servo position holding
// - function 47 suppresses warnings and protection trips
// - function 48 enables braking in acceleration when braking level above 0
// - function 49 on allows writes; unassigned, stored protection decides
// - function 50 blocks automatic start with run present at power-up
// - function 51 on selects position control, off speed control
// - function 52 enables multi-position; 53 is two-wire self-hold stop
// - function 58 becoming active requests stop with configured method
// - function 62 honoured only while supply voltage is low
// - each relay has a selector: 0 running, 1 fault, 9 blocked, others
// - relay codes 4 and 5: frequency above or below level with band
// - relay codes 50 to 53 use two further level and band pairs
// - relay code 21 is on after power-up with no fault
module dis_top
	import dis_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int SCAN_SHORT_CYC = DIS_SCAN_SHORT_CYC,
	parameter int SCAN_LONG_CYC = DIS_SCAN_LONG_CYC
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [7:0]        digitalInputTerminals,
	input  wire logic              driveRunning,
	input  wire logic              driveFault,
	input  wire logic              driveBaseblock,
	input  wire logic              powerUpDone,
	input  wire logic              lowVoltage,
	input  wire logic              closedLoopMode,
	input  wire logic              sensorVectorMode,
	input  wire logic [15:0]       outputFrequency,
	input  wire logic [63:0]       otherIndications,
	output logic                   firstRelayContact,
	output logic                   secondRelayContact,
	output logic                   sleepEnter,
	output logic                   encoderFeedbackDisable,
	output logic                   forceVoltsPerHertz,
	output logic                   speedIntegralReset,
	output logic                   torqueControlSelect,
	output logic                   torqueReferenceInvert,
	output logic                   zeroServoStart,
	output logic                   protectionOverride,
	output logic                   kineticEnergyBrakingAccel,
	output logic                   paramWriteEnable,
	output logic                   unattendedStartProtection,
	output logic                   positionControlSelect,
	output logic                   multiPositionEnable,
	output logic                   twoWireStop,
	output logic                   safetyStopRequest,
	output logic [1:0]             safetyStopMethod,
	output logic                   emergencyPowerSupplyMode
);
	localparam int CW = DIS_QUAL_CNT_W;

	// true when any qualified input in q carries the given function code
	function automatic logic fnActive(input logic [7:0] q,
			input logic [7:0][5:0] sel, input logic [5:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < DIS_NUM_IN; i++) begin
			hit = hit | (q[i] & (sel[i] == code));
		end
		return hit;
	endfunction

	// word merge under the AXI byte strobes
	function automatic logic [31:0] strbMerge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [DIS_NUM_RW-1:0][31:0] regs;
	logic [ADDR_W-1:0] awAddrHeld;
	logic [31:0]       wDataHeld;
	logic [3:0]        wStrbHeld;
	logic              awHeld;
	logic              wHeld;
	logic [7:0]        qualified;
	logic              act46Prev;
	logic              act58Prev;
	logic [DIS_NUM_DET-1:0] detAbove;

	// ---- register bus ----
	wire awTake = awvalid && awready;
	wire wTake = wvalid && wready;
	wire bDone = bvalid && bready;
	wire arTake = arvalid && arready;
	wire rDone = rvalid && rready;
	wire wrDo = awHeld && wHeld && !bvalid;
	wire [3:0] wIdx = awAddrHeld[5:2];
	wire [3:0] rIdx = araddr[5:2];
	wire wHigh = (ADDR_W > 6) ? |(awAddrHeld >> 6) : 1'b0;
	wire rHigh = (ADDR_W > 6) ? |(araddr >> 6) : 1'b0;
	wire wMapped = !wHigh && (wIdx < 4'(DIS_NUM_RW));
	wire rMapped = !rHigh && (rIdx <= DIS_IDX_STATUS);
	wire next_awHeld = awHeld ? !bDone : awTake;
	wire next_wHeld = wHeld ? !bDone : wTake;
	wire next_rvalid = rvalid ? !rready : arTake;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			awAddrHeld <= '0;
			wDataHeld <= 32'h0000_0000;
			wStrbHeld <= 4'h0;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awready <= !next_awHeld;
			wready <= !next_wHeld;
			if (awTake) begin
				awAddrHeld <= awaddr;
			end
			if (wTake) begin
				wDataHeld <= wdata;
				wStrbHeld <= wstrb;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= DIS_RESP_OKAY;
		end else if (wrDo) begin
			bvalid <= 1'b1;
			bresp <= wMapped ? DIS_RESP_OKAY : DIS_RESP_SLVERR;
		end else if (bDone) begin
			bvalid <= 1'b0;
		end
	end

	genvar gr;
	generate
		for (gr = 0; gr < DIS_NUM_RW; gr++) begin : g_reg
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					regs[gr] <= DIS_RESET_VAL;
				end else if (wrDo && wMapped && wIdx == 4'(gr)) begin
					regs[gr] <= strbMerge(regs[gr], wDataHeld, wStrbHeld)
						& DIS_MASK[gr];
				end
			end
		end
	endgenerate

	// ---- configuration fields ----
	wire       scanLong = regs[DIS_IDX_SCAN][0];
	wire [7:0] polarity = {regs[DIS_IDX_POL_HI][3:0], regs[DIS_IDX_POL_LO][3:0]};
	wire [5:0] relay1Sel = regs[DIS_IDX_RELAY1][5:0];
	wire [5:0] relay2Sel = regs[DIS_IDX_RELAY2][5:0];
	wire [31:0] ctrl = regs[DIS_IDX_CTRL];
	wire [1:0] sleepSrc = ctrl[DIS_CTRL_SLEEP_LSB +: 2];
	wire       sleepSrcIsDi = sleepSrc == DIS_SLEEP_SRC_DI;
	wire       protectStore = ctrl[DIS_CTRL_PROTECT];
	wire       kebLevelNz = |ctrl[DIS_CTRL_KEB_LSB +: 8];
	wire [1:0] safetySel = ctrl[DIS_CTRL_SAFETY_LSB +: 2];
	wire [7:0][5:0] funcSel;

	genvar gf;
	generate
		for (gf = 0; gf < DIS_NUM_IN; gf++) begin : g_func
			assign funcSel[gf] = regs[DIS_IDX_FUNC_LO + 4'(gf / 4)]
				[(gf % 4) * 8 +: 6];
		end
	endgenerate

	// ---- input conditioning ----
	// polarity first so the wait measures the command level, not the wire
	wire [7:0] sensed = digitalInputTerminals ^ polarity;
	wire [CW-1:0] qualLimit = scanLong ? CW'(SCAN_LONG_CYC)
		: CW'(SCAN_SHORT_CYC);

	genvar gi;
	generate
		for (gi = 0; gi < DIS_NUM_IN; gi++) begin : g_qual
			dis_input_qual #(.CNT_W(CW)) u_qual (
				.mclk  (mclk),
				.rst_n (rst_n),
				.din   (sensed[gi]),
				.limit (qualLimit),
				.q     (qualified[gi])
			);
		end
	endgenerate

	// ---- function decode ----
	wire act41 = fnActive(qualified, funcSel, DIS_FN_SLEEP);
	wire act42 = fnActive(qualified, funcSel, DIS_FN_ENC_OFF);
	wire act43 = fnActive(qualified, funcSel, DIS_FN_INTEG_RST);
	wire act44 = fnActive(qualified, funcSel, DIS_FN_SPD_TRQ);
	wire asg44 = fnActive(8'hFF, funcSel, DIS_FN_SPD_TRQ);
	wire act45 = fnActive(qualified, funcSel, DIS_FN_TRQ_NEG);
	wire act46 = fnActive(qualified, funcSel, DIS_FN_ZERO_SERVO);
	wire act47 = fnActive(qualified, funcSel, DIS_FN_FIRE);
	wire act48 = fnActive(qualified, funcSel, DIS_FN_KEB);
	wire act49 = fnActive(qualified, funcSel, DIS_FN_WRITE_EN);
	wire asg49 = fnActive(8'hFF, funcSel, DIS_FN_WRITE_EN);
	wire act50 = fnActive(qualified, funcSel, DIS_FN_USP);
	wire act51 = fnActive(qualified, funcSel, DIS_FN_POS_SPD);
	wire act52 = fnActive(qualified, funcSel, DIS_FN_MULTI_POS);
	wire act53 = fnActive(qualified, funcSel, DIS_FN_TWO_WIRE);
	wire act58 = fnActive(qualified, funcSel, DIS_FN_SAFETY);
	wire act62 = fnActive(qualified, funcSel, DIS_FN_EPS);

	wire next_sleep = act41 && sleepSrcIsDi;
	wire next_integ = act43 && closedLoopMode;
	// outside sensor vector mode the switch is ignored and speed stays on
	wire next_torque = sensorVectorMode && asg44 && !act44;
	wire next_zeroServo = act46 && !act46Prev;
	wire next_keb = act48 && kebLevelNz;
	wire next_writeEn = asg49 ? act49 : !protectStore;
	wire next_safety = act58 && !act58Prev;
	wire next_eps = act62 && lowVoltage;

	// ---- relay indications ----
	genvar gd;
	generate
		for (gd = 0; gd < DIS_NUM_DET; gd++) begin : g_det
			dis_freq_det #(.W(16)) u_det (
				.mclk  (mclk),
				.rst_n (rst_n),
				.freq  (outputFrequency),
				.level (regs[DIS_IDX_DET1 + 4'(gd)][15:0]),
				.band  (regs[DIS_IDX_DET1 + 4'(gd)][31:16]),
				.above (detAbove[gd])
			);
		end
	endgenerate

	wire driveReady = powerUpDone && !driveFault;
	// bit n of the vector is what relay code n shows
	wire [63:0] indRaw = {otherIndications[63:54],
		!detAbove[2], detAbove[2], !detAbove[1], detAbove[1],
		otherIndications[49:22], driveReady, otherIndications[20:10],
		driveBaseblock, otherIndications[8:6],
		!detAbove[0], detAbove[0],
		otherIndications[3:2], driveFault, driveRunning};
	wire [63:0] indication = indRaw & ~DIS_RELAY_RSVD;
	wire next_relay1 = indication[relay1Sel];
	wire next_relay2 = indication[relay2Sel];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			firstRelayContact <= 1'b0;
			secondRelayContact <= 1'b0;
			sleepEnter <= 1'b0;
			encoderFeedbackDisable <= 1'b0;
			forceVoltsPerHertz <= 1'b0;
			speedIntegralReset <= 1'b0;
			torqueControlSelect <= 1'b0;
			torqueReferenceInvert <= 1'b0;
			zeroServoStart <= 1'b0;
			protectionOverride <= 1'b0;
			kineticEnergyBrakingAccel <= 1'b0;
			paramWriteEnable <= 1'b0;
			unattendedStartProtection <= 1'b0;
			positionControlSelect <= 1'b0;
			multiPositionEnable <= 1'b0;
			twoWireStop <= 1'b0;
			safetyStopRequest <= 1'b0;
			safetyStopMethod <= 2'h0;
			emergencyPowerSupplyMode <= 1'b0;
			act46Prev <= 1'b0;
			act58Prev <= 1'b0;
		end else begin
			firstRelayContact <= next_relay1;
			secondRelayContact <= next_relay2;
			sleepEnter <= next_sleep;
			encoderFeedbackDisable <= act42;
			forceVoltsPerHertz <= act42;
			speedIntegralReset <= next_integ;
			torqueControlSelect <= next_torque;
			torqueReferenceInvert <= act45;
			zeroServoStart <= next_zeroServo;
			protectionOverride <= act47;
			kineticEnergyBrakingAccel <= next_keb;
			paramWriteEnable <= next_writeEn;
			unattendedStartProtection <= act50;
			positionControlSelect <= act51;
			multiPositionEnable <= act52;
			twoWireStop <= act53;
			safetyStopRequest <= next_safety;
			safetyStopMethod <= safetySel;
			emergencyPowerSupplyMode <= next_eps;
			act46Prev <= act46;
			act58Prev <= act58;
		end
	end

	// ---- read path ----
	wire [31:0] statusWord = {20'h0_0000, sleepEnter, paramWriteEnable,
		secondRelayContact, firstRelayContact, qualified};
	wire [31:0] readWord = (rIdx == DIS_IDX_STATUS) ? statusWord
		: regs[rIdx[3:0] < 4'(DIS_NUM_RW) ? rIdx : 4'h0];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			arready <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= DIS_RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			arready <= !next_rvalid;
			if (arTake) begin
				rdata <= rMapped ? readWord : 32'h0000_0000;
				rresp <= rMapped ? DIS_RESP_OKAY : DIS_RESP_SLVERR;
			end
		end
	end

	// ---- checks ----
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_sleep_gate: assert property (sleepEnter |-> $past(sleepSrcIsDi))
		else $error("sleep entered without digital input source");
	a_vf_force: assert property ($rose(act42) |=> encoderFeedbackDisable
		&& forceVoltsPerHertz)
		else $error("encoder disable did not force volts per hertz");
	a_integ_closed: assert property (speedIntegralReset
		|-> $past(closedLoopMode))
		else $error("integral reset outside closed loop");
	a_torque_sv: assert property (torqueControlSelect
		|-> $past(sensorVectorMode))
		else $error("torque mode selected outside sensor vector");
	a_keb_level: assert property (kineticEnergyBrakingAccel
		|-> $past(kebLevelNz))
		else $error("braking in acceleration with zero level");
	// the first edge after reset still shows the reset value of the output
	a_write_prot: assert property ($past(rst_n) && !$past(asg49)
		|-> paramWriteEnable == !$past(protectStore))
		else $error("stored protection ignored with no input assigned");
	a_safety_pulse: assert property ($rose(act58)
		|=> safetyStopRequest ##1 !safetyStopRequest)
		else $error("safety stop request not a single pulse");
	a_eps_lowv: assert property (emergencyPowerSupplyMode
		|-> $past(lowVoltage))
		else $error("emergency supply mode without low voltage");
	a_relay_ready: assert property (relay1Sel == 6'h15 && driveReady
		&& $stable(relay1Sel) |=> firstRelayContact)
		else $error("ready relay off after power-up without fault");
	a_relay_rsvd: assert property (DIS_RELAY_RSVD[relay2Sel]
		|=> !secondRelayContact)
		else $error("reserved relay code closed the contact");

	c_relay_on: cover property ($rose(firstRelayContact));
	c_safety: cover property (safetyStopRequest);
	c_sleep: cover property ($rose(sleepEnter));
	c_write_rsp: cover property (bvalid && bready);
endmodule

// ---- dis_switch_model.sv ----
// external switch contacts wired to the digital input terminals
`timescale 1ns/1ps
module dis_switch_model (
	input  wire logic [7:0] actuated,
	input  wire logic [7:0] normallyClosed,
	output logic      [7:0] terminals
);
	// a normally closed contact conducts until it is actuated
	assign terminals = actuated ^ normallyClosed;
endmodule

// ---- tb_drive_digital_input_relay_select.sv ----
// bench for digital input conditioning, function decode and relay select
`timescale 1ns/1ps
module tb_drive_digital_input_relay_select;
	import dis_pkg::*;
	logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr, terms, act, ncType;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        run, flt, bblk, pud, r1, r2, slp, tinv, pwe;
	logic        lv, clm, svm, emergency_power_supply_mode, sir, tsel;
	logic [15:0] freq;
	logic [63:0] other;
	int          n_errors, compares;

	dis_switch_model dis_switch_model_i (.actuated(act),
		.normallyClosed(ncType), .terminals(terms));
	// short counts keep the run brief: 4 and 8 cycles stand for 4 and 8 ms
	dis_top #(.SCAN_SHORT_CYC(4), .SCAN_LONG_CYC(8)) dis_top_i (
		.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.digitalInputTerminals(terms), .driveRunning(run),
		.driveFault(flt), .driveBaseblock(bblk), .powerUpDone(pud),
		.lowVoltage(lv), .closedLoopMode(clm), .sensorVectorMode(svm),
		.outputFrequency(freq), .otherIndications(other),
		.firstRelayContact(r1), .secondRelayContact(r2),
		.sleepEnter(slp), .encoderFeedbackDisable(),
		.forceVoltsPerHertz(), .speedIntegralReset(sir),
		.torqueControlSelect(tsel), .torqueReferenceInvert(tinv),
		.zeroServoStart(), .protectionOverride(),
		.kineticEnergyBrakingAccel(), .paramWriteEnable(pwe),
		.unattendedStartProtection(), .positionControlSelect(),
		.multiPositionEnable(), .twoWireStop(), .safetyStopRequest(),
		.safetyStopMethod(), .emergencyPowerSupplyMode(emergency_power_supply_mode));

	task automatic finish_test;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic tmo;
		n_errors++;
		finish_test();
	endtask
	task automatic chk1(input string nm, input logic e, input logic s);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", nm, e, s);
		end
	endtask
	task automatic chk32(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	function automatic logic [7:0] ad(input logic [3:0] i);
		return {2'h0, i, 2'h0};
	endfunction
	// each wait is bounded so a silent slave ends the run
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (r === 2'h3) begin
			@(posedge mclk);
			if (n++ > 50) tmo();
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				bready <= 1'b0;
				r = bresp;
			end
		end
		// let an edge pass so a following call never re-raises bready at once
		@(posedge mclk);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (r === 2'h3) begin
			@(posedge mclk);
			if (n++ > 50) tmo();
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				rready <= 1'b0;
				d = rdata;
				r = rresp;
			end
		end
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axw(a, d, r);
		chk32("bresp", {30'h0, DIS_RESP_OKAY}, {30'h0, r});
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		axr(ad(DIS_IDX_POL_LO), d, r);
		chk32("pol_lo reset", 32'h0000_0000, d);
		wr(ad(DIS_IDX_POL_LO), 32'hFFFF_FFFF);
		axr(ad(DIS_IDX_POL_LO), d, r);
		chk32("pol_lo width", 32'h0000_000F, d);
		axr(8'h40, d, r);
		chk32("unmapped rresp", {30'h0, DIS_RESP_SLVERR}, {30'h0, r});
		axw(ad(DIS_IDX_STATUS), 32'h0000_00FF, r);
		chk32("status bresp", {30'h0, DIS_RESP_SLVERR}, {30'h0, r});
	endtask
	task automatic t_qual;
		ncType[0] <= 1'b1;
		wr(ad(DIS_IDX_POL_LO), 32'h0000_0001);
		wr(ad(DIS_IDX_FUNC_LO), {26'h0, DIS_FN_TRQ_NEG});
		cyc(12);
		chk1("nc idle", 1'b0, tinv);
		act[0] <= 1'b1;
		cyc(2);
		act[0] <= 1'b0;
		cyc(6);
		chk1("glitch", 1'b0, tinv);
		act[0] <= 1'b1;
		cyc(3);
		chk1("short early", 1'b0, tinv);
		cyc(5);
		chk1("short done", 1'b1, tinv);
		wr(ad(DIS_IDX_SCAN), 32'h0000_0001);
		// flipping polarity must pass through the qualifier too
		wr(ad(DIS_IDX_POL_LO), 32'h0000_0000);
		chk1("pol qualified", 1'b1, tinv);
		cyc(12);
		chk1("pol settled", 1'b0, tinv);
		wr(ad(DIS_IDX_POL_LO), 32'h0000_0001);
		cyc(6);
		chk1("long early", 1'b0, tinv);
		cyc(6);
		chk1("long done", 1'b1, tinv);
	endtask
	task automatic t_func;
		wr(ad(DIS_IDX_CTRL), {30'h0, DIS_SLEEP_SRC_DI});
		wr(ad(DIS_IDX_POL_HI), 32'h0000_0001);
		ncType[4] <= 1'b1;
		cyc(4);
		chk1("pwe none", 1'b1, pwe);
		wr(ad(DIS_IDX_FUNC_HI), {18'h0, DIS_FN_SLEEP, 2'h0, DIS_FN_WRITE_EN});
		cyc(12);
		chk1("pwe off", 1'b0, pwe);
		act[4] <= 1'b1;
		act[5] <= 1'b1;
		cyc(12);
		chk1("pwe on", 1'b1, pwe);
		chk1("sleep", 1'b1, slp);
		wr(ad(DIS_IDX_CTRL), 32'h0000_0000);
		cyc(4);
		chk1("sleep src", 1'b0, slp);
		wr(ad(DIS_IDX_FUNC_HI), 32'h0000_0000);
		wr(ad(DIS_IDX_CTRL), 32'h0000_0004);
		cyc(4);
		chk1("pwe stored", 1'b0, pwe);
	endtask
	task automatic rc(input logic [5:0] c, input logic e);
		wr(ad(DIS_IDX_RELAY1), {26'h0, c});
		wr(ad(DIS_IDX_RELAY2), {26'h0, c});
		cyc(4);
		chk1("relay1", e, r1);
		chk1("relay2", e, r2);
	endtask
	task automatic t_relay;
		run <= 1'b1;
		rc(6'h00, 1'b1);
		run <= 1'b0;
		rc(6'h00, 1'b0);
		flt <= 1'b1;
		pud <= 1'b1;
		rc(6'h01, 1'b1);
		rc(6'h15, 1'b0);
		flt <= 1'b0;
		rc(6'h15, 1'b1);
		bblk <= 1'b1;
		rc(6'h09, 1'b1);
		other <= 64'hFFFF_FFFF_FFFF_FFFF;
		rc(6'h07, 1'b0);
		wr(ad(DIS_IDX_DET1), {16'h000A, 16'h0064});
		wr(ad(DIS_IDX_DET1) + 8'h04, {16'h000A, 16'h0064});
		freq <= 16'h00C8;
		rc(6'h04, 1'b1);
		freq <= 16'h005F;
		rc(6'h04, 1'b1);
		rc(6'h32, 1'b1);
		freq <= 16'h0032;
		rc(6'h04, 1'b0);
		rc(6'h05, 1'b1);
		rc(6'h33, 1'b1);
	endtask
	task automatic t_modes;
		wr(ad(DIS_IDX_FUNC_LO), {26'h0, DIS_FN_SPD_TRQ});
		wr(ad(DIS_IDX_FUNC_HI), {18'h0, DIS_FN_INTEG_RST, 2'h0, DIS_FN_EPS});
		cyc(4);
		chk1("eps no lowv", 1'b0, emergency_power_supply_mode);
		chk1("integ open", 1'b0, sir);
		svm <= 1'b1;
		lv <= 1'b1;
		clm <= 1'b1;
		cyc(4);
		chk1("speed on", 1'b0, tsel);
		chk1("eps lowv", 1'b1, emergency_power_supply_mode);
		chk1("integ closed", 1'b1, sir);
		act[0] <= 1'b0;
		cyc(12);
		chk1("torque off", 1'b1, tsel);
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, act, ncType} = 64'h0;
		wstrb = 4'hF;
		{run, flt, bblk, pud, freq, other} = 84'h0;
		{lv, clm, svm} = 3'h0;
		n_errors = 0;
		compares = 0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		cyc(2);
		t_regs();
		t_qual();
		t_func();
		t_relay();
		t_modes();
		finish_test();
	end
endmodule
